// ==== remap_cmd_pkg.sv ====
// package: register map, field positions and reset values of the command block
package remap_cmd_pkg;
  localparam int          ADDR_W           = 8;
  localparam logic [7:0]  CMD_OFFSET       = 8'h18;
  localparam logic [7:0]  STS_OFFSET       = 8'h1C;
  localparam logic [7:0]  CTRL_OFFSET      = 8'h20;
  localparam logic [7:0]  TABLE_OFFSET     = 8'h24;
  localparam int          QINVAL_CMD_BIT   = 26;
  localparam int          REMAP_CMD_BIT    = 25;
  localparam int          LOAD_PTR_CMD_BIT = 24;
  localparam int          COMPAT_CMD_BIT   = 23;
  localparam int          STS_QINVAL_BIT   = 26;
  localparam int          STS_REMAP_BIT    = 25;
  localparam int          STS_PTR_BIT      = 24;
  localparam int          STS_COMPAT_BIT   = 23;
  localparam int          CTRL_QI_SUP_BIT  = 0;
  localparam int          CTRL_IR_SUP_BIT  = 1;
  localparam int          CTRL_ETP_BIT     = 2;
  localparam int          CTRL_WBF_BIT     = 3;
  localparam int          CTRL_EIM_BIT     = 4;
  localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;
  localparam logic [31:0] CTRL_RESET       = 32'h0000_0007;
  localparam logic [31:0] TABLE_RESET      = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_LOAD  = 3'b001,
    ST_DRAIN = 3'b010,
    ST_APPLY = 3'b011,
    ST_INVAL = 3'b100
  } ir_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic qinval_enabled_status;
    logic irq_remap_enabled_status;
    logic remap_table_ptr_status;
    logic compat_irq_pass_status;
  } status_t;
endpackage : remap_cmd_pkg

// ==== remap_global_command_low.sv ====
// register bank for the lower global command bits and their status
//
// Summary of operation
// - queued-invalidation bit enables or disables processing
// - queued-invalidation bit only honoured when supported
// - queued-invalidation status reflects resulting state
// - command bits read back undefined, here zero
// - remap bit enables or disables remapping, when supported
// - remap status reports each enable/disable outcome
// - remapping switches only between interrupt transactions
// - disable with enhanced pointer invalidates remap caches
// - drain queued interrupts before completing enable
// - table-pointer command loads pointer from address register
// - table-pointer status signals load completion
// - writing zero to table-pointer command does nothing
// - compat bit zero blocks, one passes compat interrupts
// - compat bit needs remapping on, extended mode off
// - compat status reflects each compat bit update
// - flush write buffers before cache invalidation when CTRL_WBF_BIT is set
// - remap status reads one when enabled, resets zero
// - queued-invalidation status zero while not enabled
`timescale 1ns/100ps
module remap_global_command_low (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  // register port
  input  wire remap_cmd_pkg::reg_req_t req,
  output logic [31:0]                rdata,
  // interrupt path handshake
  input  wire logic                  irq_in_flight,
  input  wire logic                  irq_queue_empty,
  input  wire logic                  compat_irq,
  // cache and write buffer handshake
  output logic                       wbuf_flush_req,
  input  wire logic                  wbuf_flush_done,
  output logic                       irq_cache_inval_req,
  input  wire logic                  irq_cache_inval_done,
  // state seen by the datapath
  output logic                       qinval_active,
  output logic                       irq_remap_active,
  output logic [31:0]                remap_table_ptr,
  output logic                       compat_irq_block,
  output remap_cmd_pkg::status_t     status
);

  // register decode
  wire wr_cmd   = req.wr && (req.addr == remap_cmd_pkg::CMD_OFFSET);
  wire wr_ctrl  = req.wr && (req.addr == remap_cmd_pkg::CTRL_OFFSET);
  wire wr_table = req.wr && (req.addr == remap_cmd_pkg::TABLE_OFFSET);

  logic [31:0] ctrl_reg;
  logic [31:0] table_addr_reg;
  logic        qi_reg;
  logic        remap_on_reg;
  logic        ptr_done_reg;
  logic        compat_pass_reg;
  logic        remap_want_reg;
  logic        load_pend_reg;
  logic        remap_pend_reg;
  logic [31:0] ptr_reg;
  logic [31:0] rdata_reg;
  remap_cmd_pkg::ir_state_t state_reg;
  remap_cmd_pkg::ir_state_t state_next;

  wire qi_sup  = ctrl_reg[remap_cmd_pkg::CTRL_QI_SUP_BIT];
  wire ir_sup  = ctrl_reg[remap_cmd_pkg::CTRL_IR_SUP_BIT];
  wire etp_cap = ctrl_reg[remap_cmd_pkg::CTRL_ETP_BIT];
  wire wbf_req = ctrl_reg[remap_cmd_pkg::CTRL_WBF_BIT];
  wire eim_on  = ctrl_reg[remap_cmd_pkg::CTRL_EIM_BIT];

  // command bits as written in this cycle
  wire cmd_qinval   = req.wdata[remap_cmd_pkg::QINVAL_CMD_BIT];
  wire cmd_remap    = req.wdata[remap_cmd_pkg::REMAP_CMD_BIT];
  wire cmd_load_ptr = req.wdata[remap_cmd_pkg::LOAD_PTR_CMD_BIT];
  wire cmd_compat   = req.wdata[remap_cmd_pkg::COMPAT_CMD_BIT];

  // control and table address registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl_reg       <= remap_cmd_pkg::CTRL_RESET;
      table_addr_reg <= remap_cmd_pkg::TABLE_RESET;
    end else begin
      if (wr_ctrl) ctrl_reg <= req.wdata;
      if (wr_table) table_addr_reg <= req.wdata;
    end
  end

  // queued invalidation, applied at once
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      qi_reg <= 1'b0;
    end else if (wr_cmd && qi_sup) begin
      qi_reg <= cmd_qinval;
    end
  end

  // compat bit, status follows the write
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      compat_pass_reg <= 1'b0;
    end else if (wr_cmd && ir_sup) begin
      compat_pass_reg <= cmd_compat;
    end
  end

  // latch pending remap requests; a later write overrides an earlier one
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      remap_want_reg <= 1'b0;
      load_pend_reg  <= 1'b0;
      remap_pend_reg <= 1'b0;
    end else begin
      if (wr_cmd && ir_sup && cmd_load_ptr) begin
        load_pend_reg <= 1'b1;
      end else if (state_reg == remap_cmd_pkg::ST_LOAD) begin
        load_pend_reg <= 1'b0;
      end
      if (wr_cmd && ir_sup && (cmd_remap != remap_want_reg)) begin
        remap_want_reg <= cmd_remap;
        remap_pend_reg <= 1'b1;
      end else if (state_reg == remap_cmd_pkg::ST_APPLY) begin
        remap_pend_reg <= 1'b0;
      end
    end
  end

  // sequencer: pointer load, drain, boundary switch, invalidation
  wire at_boundary = !irq_in_flight;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      remap_cmd_pkg::ST_IDLE: begin
        if (load_pend_reg) state_next = remap_cmd_pkg::ST_LOAD;
        else if (remap_pend_reg && remap_want_reg)
          state_next = remap_cmd_pkg::ST_DRAIN;
        else if (remap_pend_reg) state_next = remap_cmd_pkg::ST_APPLY;
      end
      remap_cmd_pkg::ST_LOAD: state_next = remap_cmd_pkg::ST_IDLE;
      remap_cmd_pkg::ST_DRAIN: begin
        if (irq_queue_empty) state_next = remap_cmd_pkg::ST_APPLY;
      end
      remap_cmd_pkg::ST_APPLY: begin
        if (at_boundary) begin
          if (!remap_want_reg && etp_cap)
            state_next = remap_cmd_pkg::ST_INVAL;
          else
            state_next = remap_cmd_pkg::ST_IDLE;
        end
      end
      remap_cmd_pkg::ST_INVAL: begin
        if (irq_cache_inval_done && !wbuf_flush_req)
          state_next = remap_cmd_pkg::ST_IDLE;
      end
      default: state_next = remap_cmd_pkg::ST_IDLE;
    endcase
  end

  // apply the switch; state holds in APPLY until a boundary
  wire apply_now = (state_reg == remap_cmd_pkg::ST_APPLY) && at_boundary;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= remap_cmd_pkg::ST_IDLE;
      remap_on_reg <= 1'b0;
      ptr_done_reg <= 1'b0;
      ptr_reg      <= remap_cmd_pkg::TABLE_RESET;
    end else begin
      state_reg <= state_next;
      if (apply_now) remap_on_reg <= remap_want_reg;
      if (wr_cmd && ir_sup && cmd_load_ptr) begin
        ptr_done_reg <= 1'b0;
      end else if (state_reg == remap_cmd_pkg::ST_LOAD) begin
        ptr_reg      <= table_addr_reg;
        ptr_done_reg <= 1'b1;
      end
    end
  end

  // write buffer flush precedes the cache invalidation
  logic flushed_reg;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flushed_reg <= 1'b0;
    end else if (state_reg != remap_cmd_pkg::ST_INVAL) begin
      flushed_reg <= 1'b0;
    end else if (wbuf_flush_done) begin
      flushed_reg <= 1'b1;
    end
  end
  wire in_inval = (state_reg == remap_cmd_pkg::ST_INVAL);
  assign wbuf_flush_req = in_inval && wbf_req && !flushed_reg;
  assign irq_cache_inval_req = in_inval && !wbuf_flush_req;

  // datapath view
  assign qinval_active    = qi_reg;
  assign irq_remap_active = remap_on_reg;
  assign remap_table_ptr  = ptr_reg;
  // compat gate only meaningful with remapping on and extended mode off
  assign compat_irq_block = compat_irq && remap_on_reg && !eim_on
                            && !compat_pass_reg;

  assign status.qinval_enabled_status    = qi_reg;
  assign status.irq_remap_enabled_status = remap_on_reg;
  assign status.remap_table_ptr_status   = ptr_done_reg;
  assign status.compat_irq_pass_status   = compat_pass_reg;

  // read mux; command word reads zero, unmapped reads zero
  logic [31:0] sts_word;
  always_comb begin
    sts_word = remap_cmd_pkg::ZERO_WORD;
    sts_word[remap_cmd_pkg::STS_QINVAL_BIT] = qi_reg;
    sts_word[remap_cmd_pkg::STS_REMAP_BIT]  = remap_on_reg;
    sts_word[remap_cmd_pkg::STS_PTR_BIT]    = ptr_done_reg;
    sts_word[remap_cmd_pkg::STS_COMPAT_BIT] = compat_pass_reg;
  end
  wire [31:0] rd_mux =
    (req.addr == remap_cmd_pkg::STS_OFFSET)   ? sts_word :
    (req.addr == remap_cmd_pkg::CTRL_OFFSET)  ? ctrl_reg :
    (req.addr == remap_cmd_pkg::TABLE_OFFSET) ? table_addr_reg :
    remap_cmd_pkg::ZERO_WORD;

  always_ff @(posedge clk) begin
    if (!rst_n) rdata_reg <= remap_cmd_pkg::ZERO_WORD;
    else if (req.rd) rdata_reg <= rd_mux;
    else rdata_reg <= remap_cmd_pkg::ZERO_WORD;
  end
  assign rdata = rdata_reg;

  // assertions
  property p_qi_follow;
    @(posedge clk) disable iff (!rst_n)
      (wr_cmd && qi_sup) |=> (qi_reg == $past(cmd_qinval));
  endproperty
  a_qi_follow: assert property (p_qi_follow)
    else $error("queued invalidation did not follow write");

  property p_qi_unsup;
    @(posedge clk) disable iff (!rst_n)
      (!qi_sup && !qi_reg) |=> !qi_reg;
  endproperty
  a_qi_unsup: assert property (p_qi_unsup)
    else $error("queued invalidation set while unsupported");

  property p_cmd_read_zero;
    @(posedge clk) disable iff (!rst_n)
      (req.rd && req.addr == remap_cmd_pkg::CMD_OFFSET) |=> rdata == 32'h0;
  endproperty
  a_cmd_read_zero: assert property (p_cmd_read_zero)
    else $error("command register read nonzero");

  property p_boundary;
    @(posedge clk) disable iff (!rst_n)
      irq_in_flight |=> $stable(remap_on_reg);
  endproperty
  a_boundary: assert property (p_boundary)
    else $error("remap state changed mid transaction");

  property p_drain;
    @(posedge clk) disable iff (!rst_n)
      $rose(remap_on_reg) |-> $past(state_reg) == remap_cmd_pkg::ST_APPLY;
  endproperty
  a_drain: assert property (p_drain)
    else $error("remap enabled without drain sequence");

  property p_load;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == remap_cmd_pkg::ST_LOAD)
        && !(wr_cmd && ir_sup && cmd_load_ptr)
        |=> ptr_done_reg && ptr_reg == $past(table_addr_reg);
  endproperty
  a_load: assert property (p_load)
    else $error("pointer load did not complete");

  property p_flush_first;
    @(posedge clk) disable iff (!rst_n)
      (irq_cache_inval_req && wbf_req) |-> flushed_reg;
  endproperty
  a_flush_first: assert property (p_flush_first)
    else $error("invalidation before write buffer flush");

  property p_compat;
    @(posedge clk) disable iff (!rst_n)
      (compat_irq && compat_pass_reg) |-> !compat_irq_block;
  endproperty
  a_compat: assert property (p_compat)
    else $error("compat interrupt blocked while pass set");

  property p_remap_apply;
    @(posedge clk) disable iff (!rst_n)
      apply_now |=> (remap_on_reg == $past(remap_want_reg));
  endproperty
  a_remap_apply: assert property (p_remap_apply)
    else $error("remap status did not take requested state");

  property p_ptr_clear;
    @(posedge clk) disable iff (!rst_n)
      (wr_cmd && ir_sup && cmd_load_ptr) |=> !ptr_done_reg;
  endproperty
  a_ptr_clear: assert property (p_ptr_clear)
    else $error("pointer status not cleared by new load");

  property p_ptr_noop;
    @(posedge clk) disable iff (!rst_n)
      (wr_cmd && !cmd_load_ptr && state_reg != remap_cmd_pkg::ST_LOAD)
        |=> $stable(ptr_reg) && $stable(ptr_done_reg);
  endproperty
  a_ptr_noop: assert property (p_ptr_noop)
    else $error("zero load bit disturbed the pointer");

  property p_compat_follow;
    @(posedge clk) disable iff (!rst_n)
      (wr_cmd && ir_sup) |=> (compat_pass_reg == $past(cmd_compat));
  endproperty
  a_compat_follow: assert property (p_compat_follow)
    else $error("compat status did not follow write");

  property p_inval_cache;
    @(posedge clk) disable iff (!rst_n)
      $fell(remap_on_reg) && $past(etp_cap) |-> in_inval;
  endproperty
  a_inval_cache: assert property (p_inval_cache)
    else $error("disable skipped the cache invalidation");

  property p_inval_hold;
    @(posedge clk) disable iff (!rst_n)
      (in_inval && !irq_cache_inval_done) |=> in_inval;
  endproperty
  a_inval_hold: assert property (p_inval_hold)
    else $error("invalidation left before acknowledge");

  property p_drain_hold;
    @(posedge clk) disable iff (!rst_n)
      (state_reg == remap_cmd_pkg::ST_DRAIN) && !irq_queue_empty
        |=> (state_reg == remap_cmd_pkg::ST_DRAIN) && $stable(remap_on_reg);
  endproperty
  a_drain_hold: assert property (p_drain_hold)
    else $error("enable completed with queue not drained");

  property p_sts_read;
    @(posedge clk) disable iff (!rst_n)
      (req.rd && req.addr == remap_cmd_pkg::STS_OFFSET)
        |=> rdata[remap_cmd_pkg::STS_REMAP_BIT] == $past(remap_on_reg);
  endproperty
  a_sts_read: assert property (p_sts_read)
    else $error("status read disagrees with remap state");
endmodule : remap_global_command_low

// ==== tb_top.sv ====
// self-checking bench for the lower global command bits
`timescale 1ns/100ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
  mismatches++; $display("BAD %s expected %h seen %h", nm, ex, got); end end
`define WAITF(e) begin n = 0; while (!(e) && n < 40) begin \
  @(posedge clk); n++; end #1; end
module tb_top;
  logic                    clk, rst_n;
  remap_cmd_pkg::reg_req_t req;
  logic [31:0]             rdata, remap_table_ptr, rd_val, tbl;
  logic                    irq_in_flight, irq_queue_empty, compat_irq;
  logic                    wbuf_flush_req, wbuf_flush_done;
  logic                    irq_cache_inval_req, irq_cache_inval_done;
  logic                    qinval_active, irq_remap_active, compat_irq_block;
  remap_cmd_pkg::status_t  status;
  int                      mismatches, checks_done, n;
  bit                      q, i, c;

  remap_global_command_low i_dut (
    .clk(clk), .rst_n(rst_n), .req(req), .rdata(rdata),
    .irq_in_flight(irq_in_flight), .irq_queue_empty(irq_queue_empty),
    .compat_irq(compat_irq), .wbuf_flush_req(wbuf_flush_req),
    .wbuf_flush_done(wbuf_flush_done),
    .irq_cache_inval_req(irq_cache_inval_req),
    .irq_cache_inval_done(irq_cache_inval_done),
    .qinval_active(qinval_active), .irq_remap_active(irq_remap_active),
    .remap_table_ptr(remap_table_ptr), .compat_irq_block(compat_irq_block),
    .status(status)
  );

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // command word: low reserved bits get random junk on purpose
  function automatic logic [31:0] cmd_word(input bit t, input logic [31:0] r);
    return {5'h00, q, i, t, c, r[22:0]};
  endfunction : cmd_word

  // expected status word as seen over the register port
  function automatic logic [31:0] sts_word(input bit a, b, t, d);
    return {5'h00, a, b, t, d, 23'h00_0000};
  endfunction : sts_word

  // bus write: one strobe cycle, never a wait
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req.addr  <= a;
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clk);
    req.wr    <= 1'b0;
  endtask : wr

  // bus read: data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    req.addr <= a;
    req.rd   <= 1'b1;
    @(posedge clk);
    req.rd   <= 1'b0;
    #1;
    rd_val = rdata;
  endtask : rd

  task automatic cmd(input bit t);
    wr(remap_cmd_pkg::CMD_OFFSET, cmd_word(t, $urandom));
  endtask : cmd

  // one-cycle acknowledge pulses for the flush and invalidate handshakes
  task automatic ack(input bit inval);
    @(posedge clk);
    if (inval) irq_cache_inval_done <= 1'b1;
    else wbuf_flush_done <= 1'b1;
    @(posedge clk);
    irq_cache_inval_done <= 1'b0;
    wbuf_flush_done      <= 1'b0;
  endtask : ack

  task automatic end_of_test;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_of_test

  // watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_of_test;
  end

  initial begin
    void'($urandom(32'h9a58));
    rst_n = 1'b0;
    req = '0;
    irq_in_flight = 1'b0;
    irq_queue_empty = 1'b1;
    compat_irq = 1'b0;
    wbuf_flush_done = 1'b0;
    irq_cache_inval_done = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK("status", 4'h0, status)
    `CHK("remap", 1'b0, irq_remap_active)
    rd(remap_cmd_pkg::STS_OFFSET);
    `CHK("sts_rd", 32'h0000_0000, rd_val)
    // queued invalidation on, off, then refused when unsupported
    q = 1;
    cmd(0);
    `WAITF(qinval_active === 1'b1)
    `CHK("qi_act", 1'b1, qinval_active)
    `CHK("qi_sts", 1'b1, status.qinval_enabled_status)
    q = 0;
    cmd(0);
    `WAITF(qinval_active === 1'b0)
    `CHK("qi_sts0", 1'b0, status.qinval_enabled_status)
    wr(remap_cmd_pkg::CTRL_OFFSET, 32'h0000_0006);
    q = 1;
    cmd(0);
    repeat (3) @(posedge clk);
    #1;
    `CHK("qi_unsup", 1'b0, qinval_active)
    q = 0;
    wr(remap_cmd_pkg::CTRL_OFFSET, 32'h0000_0007);
    // random table pointer loads
    for (int k = 0; k < 4; k++) begin
      tbl = $urandom;
      wr(remap_cmd_pkg::TABLE_OFFSET, tbl);
      cmd(1);
      `WAITF(remap_table_ptr === tbl)
      `CHK("ptr", tbl, remap_table_ptr)
      `CHK("ptr_sts", 1'b1, status.remap_table_ptr_status)
    end
    // zero in the load bit must leave the pointer alone
    wr(remap_cmd_pkg::TABLE_OFFSET, ~tbl);
    cmd(0);
    repeat (3) @(posedge clk);
    #1;
    `CHK("ptr_keep", tbl, remap_table_ptr)
    `CHK("ptr_sts1", 1'b1, status.remap_table_ptr_status)
    rd(remap_cmd_pkg::CMD_OFFSET);
    `CHK("cmd_rd", 32'h0000_0000, rd_val)
    // enable held off by the queue, then by an interrupt mid-way
    @(posedge clk);
    irq_queue_empty <= 1'b0;
    irq_in_flight   <= 1'b1;
    i = 1;
    cmd(0);
    repeat (10) @(posedge clk);
    #1;
    `CHK("drain", 1'b0, irq_remap_active)
    @(posedge clk);
    irq_queue_empty <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    `CHK("boundary", 1'b0, irq_remap_active)
    @(posedge clk);
    irq_in_flight <= 1'b0;
    `WAITF(irq_remap_active === 1'b1)
    `CHK("ir_act", 1'b1, irq_remap_active)
    `CHK("ir_sts", 1'b1, status.irq_remap_enabled_status)
    // compatibility interrupts blocked, passed, then extended mode
    @(posedge clk);
    compat_irq <= 1'b1;
    @(posedge clk);
    #1;
    `CHK("blk", 1'b1, compat_irq_block)
    c = 1;
    cmd(0);
    `WAITF(status.compat_irq_pass_status === 1'b1)
    `CHK("pass", 1'b0, compat_irq_block)
    `CHK("cf_sts", 1'b1, status.compat_irq_pass_status)
    c = 0;
    wr(remap_cmd_pkg::CTRL_OFFSET, 32'h0000_0017);
    cmd(0);
    repeat (3) @(posedge clk);
    #1;
    `CHK("ext", 1'b0, compat_irq_block)
    `CHK("cf_sts0", 1'b0, status.compat_irq_pass_status)
    rd(remap_cmd_pkg::STS_OFFSET);
    `CHK("sts_on", sts_word(0, 1, 1, 0), rd_val)
    // disable with enhanced pointer: flush first, then invalidate
    wr(remap_cmd_pkg::CTRL_OFFSET, 32'h0000_000F);
    i = 0;
    cmd(0);
    `WAITF(wbuf_flush_req === 1'b1)
    `CHK("flush", 1'b1, wbuf_flush_req)
    `CHK("inv_early", 1'b0, irq_cache_inval_req)
    ack(0);
    `WAITF(irq_cache_inval_req === 1'b1)
    `CHK("inval", 1'b1, irq_cache_inval_req)
    ack(1);
    `WAITF(irq_remap_active === 1'b0)
    `CHK("ir_off", 1'b0, status.irq_remap_enabled_status)
    `CHK("blk_off", 1'b0, compat_irq_block)
    // mid-run reset must clear every command effect
    q = 1;
    cmd(0);
    `WAITF(qinval_active === 1'b1)
    `CHK("qi_pre", 1'b1, qinval_active)
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    #1;
    `CHK("sts_rst", 4'h0, status)
    `CHK("ptr_rst", 32'h0000_0000, remap_table_ptr)
    end_of_test;
  end
endmodule : tb_top
